// >>> rtl/dcie_top.sv
// completion interrupt enable and pending logic with an AHB-Lite register slave
//
// Function
// R1 - every channel may raise a completion interrupt when its transfer finishes
// R2 - direct writes to enable registers are ignored
// R3 - writing one to an enable-set bit sets that enable bit
// R4 - writing one to an enable-clear bit clears it; zero leaves it
// R5 - low enable bit n belongs to channel n, channels 0 to 31
// R6 - high enable bit n belongs to channel n plus 32
// R7 - enable bit zero means disabled, one means enabled
// R8 - enable registers are read-only and reset to zero
// R9 - enable-clear registers are write-only, read zero, map low and high halves
// R10 - writing zero to an enable-set bit has no effect
// R11 - completion code n sets pending bit n until software clears it
// R12 - interrupt output high while any channel is both pending and enabled
//
// The address map and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`include "dcie_consts.svh"
module dcie_top
    import dcie_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic code_valid,
    input wire logic [5:0] completion_code,
    output logic completion_irq
);
    logic wr_pend_reg;
    dcie_reg_e addr_reg;
    logic [63:0] enable_bits;
    logic [63:0] pending_bits;
    logic [63:0] code_hit;
    logic [31:0] hrdata_next;
    logic [31:0] hrdata_reg;
    logic irq_reg;

    dcie_wr_if en_wr();
    dcie_wr_if pnd_wr();

    function automatic dcie_reg_e decode(input logic [11:0] a);
        unique case (a)
            `DCIE_OFF_ENABLE_LOW: decode = DCIE_R_EN_LO;
            `DCIE_OFF_ENABLE_HIGH: decode = DCIE_R_EN_HI;
            `DCIE_OFF_CLEAR_LOW: decode = DCIE_R_CLR_LO;
            `DCIE_OFF_CLEAR_HIGH: decode = DCIE_R_CLR_HI;
            `DCIE_OFF_SET_LOW: decode = DCIE_R_SET_LO;
            `DCIE_OFF_SET_HIGH: decode = DCIE_R_SET_HI;
            `DCIE_OFF_PENDING_LOW: decode = DCIE_R_PND_LO;
            `DCIE_OFF_PENDING_HIGH: decode = DCIE_R_PND_HI;
            `DCIE_OFF_PCLEAR_LOW: decode = DCIE_R_PCLR_LO;
            `DCIE_OFF_PCLEAR_HIGH: decode = DCIE_R_PCLR_HI;
            default: decode = DCIE_R_NONE;
        endcase
    endfunction

    // address phase capture, zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= DCIE_R_NONE;
        end else if (hready) begin
            wr_pend_reg <= hsel & htrans[1] & hwrite;
            addr_reg <= (hsel & htrans[1]) ? decode(haddr[11:0]) : DCIE_R_NONE;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // write data becomes one-cycle masks; zeros have no effect
    always_comb begin
        en_wr.set_mask = '0;
        en_wr.clr_mask = '0;
        pnd_wr.set_mask = '0;
        pnd_wr.clr_mask = '0;
        if (wr_pend_reg) begin
            unique case (addr_reg)
                DCIE_R_SET_LO: en_wr.set_mask[31:0] = hwdata; // [R3] [R10] [R5]
                DCIE_R_SET_HI: en_wr.set_mask[63:32] = hwdata; // [R3] [R10] [R6]
                DCIE_R_CLR_LO: en_wr.clr_mask[31:0] = hwdata; // [R4] [R9]
                DCIE_R_CLR_HI: en_wr.clr_mask[63:32] = hwdata; // [R4] [R9]
                DCIE_R_PCLR_LO: pnd_wr.clr_mask[31:0] = hwdata; // [R11]
                DCIE_R_PCLR_HI: pnd_wr.clr_mask[63:32] = hwdata; // [R11]
                // enable and pending registers drop direct writes
                default: en_wr.set_mask = '0; // [R2]
            endcase
        end
    end

    // enables: no hardware event, reset to zero
    dcie_bitbank #(.N(64), .EVENT_WINS(1'b1)) u_enable (
        .hclk(hclk),
        .hresetn(hresetn),
        .event_set(64'h0000_0000_0000_0000),
        .wr(en_wr.dst),
        .bits_reg(enable_bits)
    ); // [R8] [R7]

    dcie_code_decode u_decode (
        .code_valid(code_valid),
        .code(completion_code),
        .hit(code_hit)
    ); // [R1]

    // pending: sticky, a new code beats a same-cycle clear
    dcie_bitbank #(.N(64), .EVENT_WINS(1'b1)) u_pending (
        .hclk(hclk),
        .hresetn(hresetn),
        .event_set(code_hit),
        .wr(pnd_wr.dst),
        .bits_reg(pending_bits)
    ); // [R11]

    // read word of one register; write-only and unmapped addresses read zero
    function automatic logic [31:0] read_word(input dcie_reg_e r, input logic [63:0] en,
        input logic [63:0] pn);
        unique case (r)
            DCIE_R_EN_LO: read_word = en[31:0]; // [R5] [R8]
            DCIE_R_EN_HI: read_word = en[63:32]; // [R6] [R8]
            DCIE_R_PND_LO: read_word = pn[31:0]; // [R11]
            DCIE_R_PND_HI: read_word = pn[63:32]; // [R11]
            default: read_word = `DCIE_RESET_WORD; // [R9]
        endcase
    endfunction

    // read word picked at the address phase so hrdata comes from a flop;
    // a read issued during a write's data phase sees the state before that write
    always_comb begin
        hrdata_next = `DCIE_RESET_WORD;
        if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata_next = read_word(decode(haddr[11:0]), enable_bits, pending_bits);
        end
    end

    // held through the data phase, zero otherwise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= `DCIE_RESET_WORD;
        end else begin
            hrdata_reg <= hrdata_next;
        end
    end

    assign hrdata = hrdata_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(pending_bits & enable_bits); // [R12] [R7]
        end
    end

    assign completion_irq = irq_reg;
endmodule

// >>> pkg/dcie_consts.svh
// register offsets, reset values and field sizes for the completion interrupt enable block
`ifndef DCIE_CONSTS_SVH
`define DCIE_CONSTS_SVH
`define DCIE_OFF_ENABLE_LOW 12'h000
`define DCIE_OFF_ENABLE_HIGH 12'h004
`define DCIE_OFF_CLEAR_LOW 12'h008
`define DCIE_OFF_CLEAR_HIGH 12'h00C
`define DCIE_OFF_SET_LOW 12'h010
`define DCIE_OFF_SET_HIGH 12'h014
`define DCIE_OFF_PENDING_LOW 12'h018
`define DCIE_OFF_PENDING_HIGH 12'h01C
`define DCIE_OFF_PCLEAR_LOW 12'h020
`define DCIE_OFF_PCLEAR_HIGH 12'h024
`define DCIE_RESET_WORD 32'h0000_0000
`define DCIE_ADDR_W 12
`define DCIE_CODE_W 6
`endif

// >>> pkg/dcie_pkg.sv
// types shared by the completion interrupt enable block
package dcie_pkg;
    typedef enum logic [3:0] {
        DCIE_R_EN_LO,
        DCIE_R_EN_HI,
        DCIE_R_CLR_LO,
        DCIE_R_CLR_HI,
        DCIE_R_SET_LO,
        DCIE_R_SET_HI,
        DCIE_R_PND_LO,
        DCIE_R_PND_HI,
        DCIE_R_PCLR_LO,
        DCIE_R_PCLR_HI,
        DCIE_R_NONE
    } dcie_reg_e;
    typedef logic [63:0] dcie_chan_t;
endpackage

// >>> pkg/dcie_wr_if.sv
// write strobes from the bus slave to the channel bit stores
`timescale 1ns/100ps
interface dcie_wr_if;
    logic [63:0] set_mask;
    logic [63:0] clr_mask;
    modport src (output set_mask, output clr_mask);
    modport dst (input set_mask, input clr_mask);
endinterface

// >>> rtl/dcie_bitbank.sv
// 64 bit store with one-to-set and one-to-clear masks, event set winning
`timescale 1ns/100ps
module dcie_bitbank
    import dcie_pkg::*;
#(
    parameter int N = 64,
    parameter bit EVENT_WINS = 1'b1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [N-1:0] event_set,
    dcie_wr_if.dst wr,
    output logic [N-1:0] bits_reg
);
    logic [N-1:0] bits_next;

    always_comb begin
        if (EVENT_WINS) begin
            bits_next = ((bits_reg | wr.set_mask) & ~wr.clr_mask) | event_set;
        end else begin
            bits_next = (bits_reg | wr.set_mask | event_set) & ~wr.clr_mask;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bits_reg <= '0;
        end else begin
            bits_reg <= bits_next;
        end
    end
endmodule

// >>> rtl/dcie_code_decode.sv
// turns a returned completion code into a one-hot channel event
`timescale 1ns/100ps
module dcie_code_decode
    import dcie_pkg::*;
(
    input wire logic code_valid,
    input wire logic [5:0] code,
    output logic [63:0] hit
);
    always_comb begin
        hit = '0;
        if (code_valid) begin
            hit[code] = 1'b1;
        end
    end
endmodule

// >>> verif/dcie_code_model.sv
// completion code source on the transfer side
`timescale 1ns/100ps
module dcie_code_model (
    input wire logic hclk,
    output logic code_valid,
    output logic [5:0] completion_code
);
    initial begin
        code_valid = 1'b0;
        completion_code = 6'h3f;
    end
    task automatic fire(input logic [5:0] n);
        code_valid <= 1'b1;
        completion_code <= n;
        @(posedge hclk);
        code_valid <= 1'b0;
        // code not held once the pulse ends
        completion_code <= ~n;
    endtask
endmodule

// >>> verif/dcie_top_monitor.sv
// assertion checker for the completion interrupt enable block
`timescale 1ns/100ps
module dcie_top_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic code_valid,
    input wire logic [5:0] completion_code,
    input wire logic completion_irq
);
    default clocking @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    logic rd_q, wr_q, any_q;
    logic [11:0] a_q;
    logic [63:0] en, pn, wd, en_a, pn_a;
    assign wd = a_q[2] ? {hwdata, 32'h0} : {32'h0, hwdata};
    // shadow of enables and pendings
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {rd_q, wr_q, any_q, a_q, en, pn, en_a, pn_a} <= '0;
        end else begin
            rd_q <= hready & hsel & htrans[1] & ~hwrite;
            wr_q <= hready & hsel & htrans[1] & hwrite;
            a_q <= haddr[11:0];
            any_q <= |(en & pn);
            // read data reflects the state seen at the address phase
            en_a <= en;
            pn_a <= pn;
            pn <= pn & ~(wr_q && a_q[11:3] == 9'h004 ? wd : '0)
                | {63'h0, code_valid} << completion_code;
            if (wr_q && a_q[11:3] == 9'h001) en <= en & ~wd;
            if (wr_q && a_q[11:3] == 9'h002) en <= en | wd;
        end
    end
    a_en_lo_read: assert property (rd_q && a_q == 12'h000 |-> hrdata == en_a[31:0])
        else $error("enable low read wrong");
    a_en_hi_read: assert property (rd_q && a_q == 12'h004 |-> hrdata == en_a[63:32])
        else $error("enable high read wrong");
    a_clr_reads_zero: assert property (rd_q && a_q[11:3] == 9'h001 |-> hrdata == '0)
        else $error("clear register read not zero");
    a_pnd_lo_read: assert property (rd_q && a_q == 12'h018 |-> hrdata == pn_a[31:0])
        else $error("pending low read wrong");
    a_pnd_hi_read: assert property (rd_q && a_q == 12'h01c |-> hrdata == pn_a[63:32])
        else $error("pending high read wrong");
    a_resp_okay: assert property (hreadyout && !hresp)
        else $error("bus response not ready okay");
    a_irq_level: assert property (completion_irq == any_q)
        else $error("irq level wrong");
    a_enabled_code_irq: assert property (code_valid && en[completion_code] && !wr_q
        |-> ##2 completion_irq) else $error("enabled code gave no irq");
    a_masked_code_quiet: assert property (code_valid && !en[completion_code] && !wr_q
        && !(|(en & pn)) |-> ##2 !completion_irq) else $error("masked code gave irq");
    c_irq_rise: cover property ($rose(completion_irq));
    c_enable_clear: cover property (wr_q && a_q[11:3] == 9'h001);
    c_code_seen: cover property (code_valid);
    c_pending_clear: cover property (wr_q && a_q[11:3] == 9'h004);
endmodule
bind dcie_top dcie_top_monitor u_dcie_top_monitor (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .code_valid,
    .completion_code, .completion_irq);

// >>> verif/tb_top.sv
// self-checking bench for the completion interrupt enable block
`timescale 1ns/100ps
module tb_top;
    logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0] htrans = 2'b00;
    logic hready, hresp, code_valid, completion_irq;
    logic [5:0] completion_code;
    int n_fail = 0, n_compared = 0;
    initial forever #20 hclk = ~hclk;
    dcie_code_model u_dcie_code_model (.hclk, .code_valid, .completion_code);
    dcie_top u_dcie_top (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'b010), .hwdata, .hready, .hrdata, .hreadyout(hready), .hresp,
        .code_valid, .completion_code, .completion_irq);
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q);
        htrans <= 2'b10;
        haddr <= {20'h0_0000, a};
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        xfer(1'b0, a, 32'h0, q);
        ck(q, exp);
    endtask
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        wrap_up;
    end
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd(12'h000, 32'h0);
        rd(12'h004, 32'h0);
        wr(12'h000, 32'hffff_ffff);
        rd(12'h000, 32'h0);
        $display("test reset and direct write done");
        wr(12'h010, 32'h8000_0001);
        wr(12'h014, 32'h1);
        wr(12'h010, 32'h0);
        rd(12'h000, 32'h8000_0001);
        rd(12'h004, 32'h1);
        wr(12'h008, 32'h1);
        wr(12'h00c, 32'h0);
        rd(12'h000, 32'h8000_0000);
        rd(12'h008, 32'h0);
        rd(12'h004, 32'h1);
        $display("test set and clear done");
        u_dcie_code_model.fire(6'd32);
        repeat (2) @(posedge hclk);
        ck({31'h0, completion_irq}, 32'h1);
        rd(12'h01c, 32'h1);
        wr(12'h024, 32'h1);
        u_dcie_code_model.fire(6'd5);
        repeat (2) @(posedge hclk);
        ck({31'h0, completion_irq}, 32'h0);
        rd(12'h018, 32'h20);
        wr(12'h010, 32'h20);
        repeat (2) @(posedge hclk);
        ck({31'h0, completion_irq}, 32'h1);
        wr(12'h00c, 32'h1);
        rd(12'h004, 32'h0);
        wr(12'h100, 32'hffff_ffff);
        rd(12'h100, 32'h0);
        $display("test completion interrupt done");
        wr(12'h020, 32'h20);
        rd(12'h018, 32'h0);
        ck({31'h0, completion_irq}, 32'h0);
        u_dcie_code_model.fire(6'd5);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ck({31'h0, completion_irq}, 32'h0);
        rd(12'h000, 32'h0);
        rd(12'h018, 32'h0);
        $display("test pending clear and mid-run reset done");
        wrap_up;
    end
endmodule
